// ===== verilog/pci_power_mgmt_regs.sv
// Power-management capabilities and control/status registers of the bridge
//
// Functional notes
// [R1] Capabilities bits 15..11, wake-event support, always read zero.
// [R2] Capabilities bit 10 reads one: D2 supported.
// [R3] Capabilities bit 9 reads one: D1 supported.
// [R4] Capabilities bit 5 reads zero: no special initialization needed.
// [R5] Capabilities bit 4, auxiliary power, read-only zero.
// [R6] Capabilities bit 3, wake clock needed, read-only zero.
// [R7] Capabilities bits 2..0 read 001: interface revision 1.0.
// [R8] Capabilities register is read-only; writes change nothing.
// [R9] Control/status bit 15, wake status, read-only zero.
// [R10] Control/status bits 14..13, data scale, read-only zero.
// [R11] Control/status bits 12..9, data select, read-only zero.
// [R12] Control/status bit 8, wake enable, read-only zero; writes ignored.
// [R13] Control/status bits 7..2 reserved, read-only zero.
// [R14] Control/status bits 1..0 hold and set power state D0..D3hot.
// [R15] Leaving D3hot for D0 raises an internal reset.
// [R16] That internal reset leaves control/status contents untouched.
// [R17] Control/status at offset 84h, resets to 0000h (D0).
// [R18] Capabilities at offset 82h, read-only, reads 0601h.
// [R19] In D3hot the secondary bus clocks are stopped.
// [R20] Capabilities bits 8..6 reserved: read zero, ignore writes.
// [R21] Power-state write takes effect at once, visible on next read.
`timescale 1ns/10ps
`default_nettype none

module pci_power_mgmt_regs
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire pm_regs_pkg::cfg_req_t cfg_req,
  output logic [31:0] cfg_rdata_r,
  output logic cfg_rvalid_r,
  output logic [1:0] power_state_r,
  output logic int_rst_r,
  output logic sec_clk_stop_r
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Dword hits for the two registers
  logic hit_cap;
  logic hit_csr;
  logic ps_wr;
  logic [1:0] ps_nxt;
  logic leave_d3;
  logic [15:0] cap_image;
  logic [15:0] csr_image;
  logic [31:0] rdata_nxt;
  logic [pm_regs_pkg::INT_RST_CNT_W-1:0] rst_cnt_r;
  logic [pm_regs_pkg::INT_RST_CNT_W-1:0] rst_cnt_nxt;

  assign hit_cap = (cfg_req.dword == pm_regs_pkg::CAP_DWORD); // [R18]
  assign hit_csr = (cfg_req.dword == pm_regs_pkg::CSR_DWORD); // [R17]

  // Only the low byte lane of the control/status word carries writable bits
  assign ps_wr = cfg_req.wr && hit_csr && cfg_req.be[pm_regs_pkg::CSR_BE_LANE]; // [R8] [R12]

  // ----------------------------------------------------------------
  // Register images
  // ----------------------------------------------------------------

  // Capabilities word built from constant fields, no storage at all
  assign cap_image = {pm_regs_pkg::CAP_WAKE_SUPPORT, // [R1]
                      pm_regs_pkg::CAP_D2_SUPPORT, // [R2]
                      pm_regs_pkg::CAP_D1_SUPPORT, // [R3]
                      pm_regs_pkg::CAP_RSVD, // [R20]
                      pm_regs_pkg::CAP_DEV_INIT, // [R4]
                      pm_regs_pkg::CAP_AUX_PWR, // [R5]
                      pm_regs_pkg::CAP_WAKE_CLK, // [R6]
                      pm_regs_pkg::CAP_VERSION}; // [R7]

  // Control/status word: only the power-state field is stored
  assign csr_image = {pm_regs_pkg::CSR_RO_ZERO, power_state_r}; // [R9] [R10] [R11] [R13]

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------

  // Next power state taken straight from the write data
  always_comb
  begin
    ps_nxt = power_state_r;
    if (ps_wr)
    begin
      ps_nxt = cfg_req.wdata[pm_regs_pkg::PS_LSB +: pm_regs_pkg::PS_W]; // [R14] [R21]
    end
  end

  // A move from D3hot straight to D0
  assign leave_d3 = (power_state_r == pm_regs_pkg::PS_D3HOT) &&
                    (ps_nxt == pm_regs_pkg::PS_D0);

  // Power-state field; the internal reset never touches it
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_state_r <= pm_regs_pkg::CSR_RESET[1:0]; // [R17]
    end
    else
    begin
      power_state_r <= ps_nxt; // [R14] [R16]
    end
  end

  // Secondary clock stop follows D3hot, updated on the same edge
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sec_clk_stop_r <= 1'b0;
    end
    else
    begin
      sec_clk_stop_r <= (ps_nxt == pm_regs_pkg::PS_D3HOT); // [R19]
    end
  end

  // ----------------------------------------------------------------
  // Internal reset on D3hot to D0
  // ----------------------------------------------------------------

  // Pulse length counter; a new exit restarts it
  always_comb
  begin
    rst_cnt_nxt = rst_cnt_r;
    if (leave_d3)
    begin
      rst_cnt_nxt = pm_regs_pkg::INT_RST_CYCLES[pm_regs_pkg::INT_RST_CNT_W-1:0]; // [R15]
    end
    else if (rst_cnt_r != '0)
    begin
      rst_cnt_nxt = rst_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_cnt_r <= '0;
    end
    else
    begin
      rst_cnt_r <= rst_cnt_nxt;
    end
  end

  // Registered reset output, high while the counter runs
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_rst_r <= 1'b0;
    end
    else
    begin
      int_rst_r <= (rst_cnt_nxt != '0); // [R15]
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Read mux; unmapped dwords and other byte lanes return zero
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (hit_cap)
    begin
      rdata_nxt[pm_regs_pkg::CAP_LANE_LSB +: 16] = cap_image; // [R18]
    end
    else if (hit_csr)
    begin
      rdata_nxt[pm_regs_pkg::CSR_LANE_LSB +: 16] = csr_image; // [R17]
    end
  end

  // Read data and its strobe, one cycle after the request
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_rdata_r <= 32'h0000_0000;
      cfg_rvalid_r <= 1'b0;
    end
    else
    begin
      cfg_rvalid_r <= cfg_req.rd;
      if (cfg_req.rd)
      begin
        cfg_rdata_r <= rdata_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  // Marks the first cycle after reset release
  logic first_r;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_r <= 1'b1;
    end
    else
    begin
      first_r <= 1'b0;
    end
  end

  sequence s_cap_read;
    cfg_req.rd && (cfg_req.dword == pm_regs_pkg::CAP_DWORD);
  endsequence

  sequence s_csr_read;
    cfg_req.rd && (cfg_req.dword == pm_regs_pkg::CSR_DWORD);
  endsequence

  sequence s_ps_write;
    cfg_req.wr && (cfg_req.dword == pm_regs_pkg::CSR_DWORD) && cfg_req.be[0];
  endsequence

  sequence s_exit_d3;
    s_ps_write ##0 (power_state_r == 2'h3) && (cfg_req.wdata[1:0] == 2'h0);
  endsequence

  a_cap_read_value: assert property (@(posedge core_clk) disable iff (!rst_n) // [R1] [R7] [R18]
    s_cap_read |=> cfg_rvalid_r && (cfg_rdata_r == 32'h0601_0000))
    else $error("capabilities read did not return 0601h");

  a_cap_write_ignored: assert property (@(posedge core_clk) disable iff (!rst_n) // [R8]
    (cfg_req.wr && (cfg_req.dword == pm_regs_pkg::CAP_DWORD)) |=> $stable(power_state_r))
    else $error("write to capabilities changed state");

  a_csr_high_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [R13]
    s_csr_read |=> cfg_rvalid_r && (cfg_rdata_r[31:2] == 30'h0000_0000))
    else $error("control/status read-only bits not zero");

  a_ps_write_takes: assert property (@(posedge core_clk) disable iff (!rst_n) // [R21]
    s_ps_write |=> (power_state_r == $past(cfg_req.wdata[1:0])))
    else $error("power state write did not take effect");

  a_ps_readback: assert property (@(posedge core_clk) disable iff (!rst_n) // [R14]
    (s_ps_write ##1 s_csr_read) |=> (cfg_rdata_r[1:0] == $past(power_state_r)))
    else $error("power state read back mismatch");

  a_csr_upper_wr: assert property (@(posedge core_clk) disable iff (!rst_n) // [R12]
    (cfg_req.wr && (cfg_req.dword == pm_regs_pkg::CSR_DWORD) && !cfg_req.be[0])
    |=> $stable(power_state_r))
    else $error("upper-lane write changed power state");

  a_int_rst_pulse: assert property (@(posedge core_clk) disable iff (!rst_n) // [R15]
    (s_exit_d3 ##1 !ps_wr[*6]) |-> $past(int_rst_r, 5) && !int_rst_r)
    else $error("internal reset pulse length wrong");

  a_int_rst_start: assert property (@(posedge core_clk) disable iff (!rst_n) // [R15]
    s_exit_d3 |=> int_rst_r && (power_state_r == 2'h0))
    else $error("internal reset missing on D3hot exit");

  a_rst_keeps_csr: assert property (@(posedge core_clk) disable iff (!rst_n) // [R16]
    (int_rst_r && !ps_wr) |=> $stable(power_state_r))
    else $error("internal reset altered control/status");

  a_clk_stop_d3: assert property (@(posedge core_clk) disable iff (!rst_n) // [R19]
    sec_clk_stop_r == (power_state_r == 2'h3))
    else $error("secondary clock stop does not follow D3hot");

  a_reset_d0: assert property (@(posedge core_clk) disable iff (!rst_n) // [R17]
    first_r |-> (power_state_r == 2'h0) && !int_rst_r && !sec_clk_stop_r)
    else $error("control/status not 0000h after reset");

  a_no_spurious_rst: assert property (@(posedge core_clk) disable iff (!rst_n) // [R15]
    $rose(int_rst_r) |-> $past(power_state_r) == 2'h3)
    else $error("internal reset without D3hot exit");

  // Field by field checks of both read words
  a_cap_wake_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [R1]
    s_cap_read |=> (cfg_rdata_r[31:27] == 5'h00))
    else $error("wake support field not zero");

  a_cap_d2_bit: assert property (@(posedge core_clk) disable iff (!rst_n) // [R2]
    s_cap_read |=> cfg_rdata_r[26])
    else $error("D2 support bit not set");

  a_cap_d1_bit: assert property (@(posedge core_clk) disable iff (!rst_n) // [R3]
    s_cap_read |=> cfg_rdata_r[25])
    else $error("D1 support bit not set");

  a_cap_rsvd_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [R20]
    s_cap_read |=> (cfg_rdata_r[24:22] == 3'h0))
    else $error("capabilities reserved bits not zero");

  a_cap_init_bit: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4]
    s_cap_read |=> !cfg_rdata_r[21])
    else $error("special initialization bit set");

  a_cap_aux_bit: assert property (@(posedge core_clk) disable iff (!rst_n) // [R5]
    s_cap_read |=> !cfg_rdata_r[20])
    else $error("auxiliary power bit set");

  a_cap_clk_bit: assert property (@(posedge core_clk) disable iff (!rst_n) // [R6]
    s_cap_read |=> !cfg_rdata_r[19])
    else $error("wake clock bit set");

  a_cap_version: assert property (@(posedge core_clk) disable iff (!rst_n) // [R7]
    s_cap_read |=> (cfg_rdata_r[18:16] == 3'h1))
    else $error("version field not 001");

  a_csr_wake_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [R9]
    s_csr_read |=> !cfg_rdata_r[15])
    else $error("wake status bit set");

  a_csr_scale_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [R10]
    s_csr_read |=> (cfg_rdata_r[14:13] == 2'h0))
    else $error("data scale field not zero");

  a_csr_select_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [R11]
    s_csr_read |=> (cfg_rdata_r[12:9] == 4'h0))
    else $error("data select field not zero");

  a_csr_enable_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [R12]
    s_csr_read |=> !cfg_rdata_r[8])
    else $error("wake enable bit set");

  a_csr_ps_field: assert property (@(posedge core_clk) disable iff (!rst_n) // [R14]
    s_csr_read |=> (cfg_rdata_r[1:0] == $past(power_state_r)))
    else $error("power state field read mismatch");

  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // [R17]
    (cfg_req.rd && !hit_cap && !hit_csr) |=> (cfg_rdata_r == 32'h0000_0000))
    else $error("unmapped read not zero");

endmodule

`default_nettype wire

// ===== include/pm_regs_pkg.sv
// Constants and carrier types for the power-management register pair
package pm_regs_pkg;

  // ----------------------------------------------------------------
  // Configuration space layout
  // ----------------------------------------------------------------
  localparam int CFG_DWORD_W = 6;
  localparam logic [7:0] CAP_OFFSET = 8'h82;
  localparam logic [7:0] CSR_OFFSET = 8'h84;
  localparam logic [5:0] CAP_DWORD = CAP_OFFSET[7:2];
  localparam logic [5:0] CSR_DWORD = CSR_OFFSET[7:2];
  localparam int CAP_LANE_LSB = 16;
  localparam int CSR_LANE_LSB = 0;
  localparam int CSR_BE_LANE = 0;

  // ----------------------------------------------------------------
  // Capabilities register fields (read-only image)
  // ----------------------------------------------------------------
  localparam logic [4:0] CAP_WAKE_SUPPORT = 5'h00;
  localparam logic CAP_D2_SUPPORT = 1'b1;
  localparam logic CAP_D1_SUPPORT = 1'b1;
  localparam logic [2:0] CAP_RSVD = 3'h0;
  localparam logic CAP_DEV_INIT = 1'b0;
  localparam logic CAP_AUX_PWR = 1'b0;
  localparam logic CAP_WAKE_CLK = 1'b0;
  localparam logic [2:0] CAP_VERSION = 3'h1;
  localparam logic [15:0] CAP_VALUE = 16'h0601;

  // ----------------------------------------------------------------
  // Control/status register fields
  // ----------------------------------------------------------------
  localparam logic [15:0] CSR_RESET = 16'h0000;
  localparam int PS_LSB = 0;
  localparam int PS_W = 2;
  localparam logic [13:0] CSR_RO_ZERO = 14'h0000;
  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D1 = 2'h1;
  localparam logic [1:0] PS_D2 = 2'h2;
  localparam logic [1:0] PS_D3HOT = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int INT_RST_NS = 40;
  localparam int INT_RST_CYCLES = (INT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INT_RST_CNT_W = 3;

  // Configuration access request, one cycle per access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] dword;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

endpackage

// ===== tb/tb_pci_power_mgmt_regs.sv
// Self-checking testbench for the power-management register pair
`timescale 1ns/10ps
`default_nettype none

module tb_pci_power_mgmt_regs;

  // ----------------------------------------------------------------
  // Clock, reset and design hookup
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  pm_regs_pkg::cfg_req_t cfg_req = '0;
  logic [31:0] cfg_rdata_r;
  logic cfg_rvalid_r;
  logic [1:0] power_state_r;
  logic int_rst_r;
  logic sec_clk_stop_r;
  int error_cnt = 0;
  int n_tests = 0;
  logic [1:0] ps_exp = 2'h0;
  logic [31:0] rnd;
  logic [3:0] seq [11] = '{4'h1, 4'h2, 4'h3, 4'h0, 4'h3, 4'h1, 4'h0, 4'h2, 4'h3, 4'h2, 4'h0};

  // Free-running 125 MHz clock
  always #4 core_clk = ~core_clk;

  pci_power_mgmt_regs DUT
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cfg_req(cfg_req),
    .cfg_rdata_r(cfg_rdata_r),
    .cfg_rvalid_r(cfg_rvalid_r),
    .power_state_r(power_state_r),
    .int_rst_r(int_rst_r),
    .sec_clk_stop_r(sec_clk_stop_r)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compare one observed value against its expectation
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // Expected control/status read word: only the power-state field is live
  function automatic logic [31:0] exp_csr(input logic [1:0] ps);
    return {30'h0, ps};
  endfunction

  // One-cycle read, answer checked while it stands, then one idle cycle
  task automatic cfg_read(input logic [5:0] dw, input logic [31:0] exp);
    cfg_req.rd = 1'b1;
    cfg_req.dword = dw;
    @(negedge core_clk);
    check("read valid", {31'h0, cfg_rvalid_r}, 32'h1);
    check("read data", cfg_rdata_r, exp);
    cfg_req.rd = 1'b0;
    @(negedge core_clk);
  endtask

  // One-cycle write pulse
  task automatic cfg_write(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd);
    cfg_req.wr = 1'b1;
    cfg_req.dword = dw;
    cfg_req.be = be;
    cfg_req.wdata = wd;
    @(negedge core_clk);
    cfg_req.wr = 1'b0;
    @(negedge core_clk);
  endtask

  // Move to a power state with random junk in the read-only bits, then check all effects
  task automatic set_ps(input logic [1:0] ps);
    logic exit_d3;
    exit_d3 = (ps_exp == pm_regs_pkg::PS_D3HOT) && (ps == pm_regs_pkg::PS_D0);
    rnd = $urandom();
    cfg_write(6'h21, 4'h1 | rnd[3:0], {rnd[31:2], ps});
    ps_exp = ps;
    check("power state", {30'h0, power_state_r}, {30'h0, ps});
    check("clock stop", {31'h0, sec_clk_stop_r}, {31'h0, ps == pm_regs_pkg::PS_D3HOT});
    check("internal reset", {31'h0, int_rst_r}, {31'h0, exit_d3});
    if (exit_d3)
    begin
      repeat (2)
      begin
        check("reset pulse", {31'h0, int_rst_r}, 32'h1);
        cfg_read(6'h21, 32'h0);
      end
      check("reset pulse end", {31'h0, int_rst_r}, 32'h0);
    end
    cfg_read(6'h21, exp_csr(ps));
  endtask

  // Print the counts and the verdict, then stop
  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rnd = $urandom(17);
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    check("reset outputs", {27'h0, power_state_r, int_rst_r, sec_clk_stop_r, cfg_rvalid_r},
      32'h0);
    cfg_read(6'h20, 32'h06010000);
    cfg_read(6'h21, 32'h0);
    cfg_write(6'h20, 4'hF, 32'hFFFFFFFF);
    cfg_read(6'h20, 32'h06010000);
    cfg_read(6'h22, 32'h0);
    // Every encoding, every exit from D3hot
    foreach (seq[i])
      set_ps(seq[i][1:0]);
    // Byte lane of the power state disabled: nothing changes
    set_ps(2'h2);
    cfg_write(6'h21, 4'hE, 32'hFFFFFFFF);
    check("lane off", {30'h0, power_state_r}, 32'h2);
    cfg_read(6'h21, 32'h2);
    // Random walk through the states, back to back
    repeat (40)
    begin
      rnd = $urandom();
      set_ps(rnd[1:0]);
    end
    // Reset in mid-run from D3hot
    set_ps(2'h3);
    rst_n = 1'b0;
    @(negedge core_clk);
    rst_n = 1'b1;
    ps_exp = 2'h0;
    check("mid-run reset", {29'h0, power_state_r, sec_clk_stop_r}, 32'h0);
    cfg_read(6'h21, 32'h0);
    final_report();
  end

  // Watchdog cuts a hang short
  initial
  begin
    #(8 * 3000);
    error_cnt++;
    final_report();
  end

endmodule

`default_nettype wire
